//--- design/bmd_decoder.sv
// Decoder for branch, compare-jump, decrement-jump and extended opcodes.
`timescale 1ns/1ps

module bmd_decoder
  import bmd_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           arst_n,
  input  wire logic           opcode_valid,
  input  wire logic [7:0]     opcode,
  input  wire logic [15:0]    opcode_pc,
  input  wire logic [7:0]     displacement,
  input  wire logic [7:0]     extended_op_select,
  input  wire logic           operand_is_input_port,
  input  wire logic [15:0]    data_pointer,
  output logic                decode_valid,
  output bmd_decode_type      decode,
  output logic [15:0]         branch_target,
  output logic [15:0]         store_address,
  output logic [15:0]         data_pointer_next
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic       rst_meta_n;
  logic       rst_n;

  // Outputs leave reset at the second edge after arst_n is released.
  // The first opcode should therefore be offered at the third edge.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ****************************************************************
  // Opcode matches
  // ****************************************************************
  logic match_jnz_acc;
  logic match_cmp_dir;
  logic match_cmp_imm;
  logic match_cmp_reg;
  logic match_cmp_ind;
  logic match_dec_reg;
  logic match_dec_dir;
  logic match_extended;
  logic match_abs_jump;
  logic match_abs_call;
  logic match_hazard_op;

  assign match_jnz_acc   = (opcode == OP_JUMP_ACC_NZ);
  assign match_cmp_dir   = (opcode == OP_CMP_A_DIR);
  assign match_cmp_imm   = (opcode == OP_CMP_A_IMM);
  assign match_cmp_reg   = (opcode[7:3] == OP_CMP_REG_BASE);
  assign match_cmp_ind   = (opcode[7:1] == OP_CMP_IND_BASE);
  assign match_dec_reg   = (opcode[7:3] == OP_DEC_REG_BASE);
  assign match_dec_dir   = (opcode == OP_DEC_DIR);
  assign match_extended  = (opcode == OP_EXTENDED);
  assign match_abs_jump  = (opcode[4:0] == OP_ABS_JUMP_LOW);
  assign match_abs_call  = (opcode[4:0] == OP_ABS_CALL_LOW);
  // Only direct byte operands of this block can sit on an input pin.
  assign match_hazard_op = match_cmp_dir || match_dec_dir;

  // ****************************************************************
  // Combinational decode
  // ****************************************************************
  bmd_decode_type next_decode;
  bmd_branch_type branch_in;
  logic [15:0]    next_target;

  always_comb begin
    next_decode             = '0;
    next_decode.op_class    = BMD_NONE;
    next_decode.valid       = 1'b0;
    next_decode.reg_num     = opcode[2:0];
    next_decode.abs_page    = opcode[7:5];
    // Absolute forms are flagged on their low five bits alone.
    if (match_abs_jump) begin
      next_decode.abs_jump = 1'b1;
      next_decode.length   = LEN_TWO;
      next_decode.cycles   = CYC_TWO;
    end
    if (match_abs_call) begin
      next_decode.abs_call = 1'b1;
      next_decode.length   = LEN_TWO;
      next_decode.cycles   = CYC_TWO;
    end
    if (match_jnz_acc) begin
      next_decode.valid    = 1'b1;
      next_decode.op_class = BMD_JNZ_ACC;
      next_decode.length   = LEN_TWO;
      next_decode.cycles   = CYC_TWO;
    end else if (match_cmp_dir) begin
      next_decode.valid    = 1'b1;
      next_decode.op_class = BMD_CMP_DIR;
      next_decode.length   = LEN_THREE;
      next_decode.cycles   = CYC_TWO;
    end else if (match_cmp_imm) begin
      next_decode.valid    = 1'b1;
      next_decode.op_class = BMD_CMP_IMM;
      next_decode.length   = LEN_THREE;
      next_decode.cycles   = CYC_TWO;
    end else if (match_cmp_reg) begin
      next_decode.valid    = 1'b1;
      next_decode.op_class = BMD_CMP_REG;
      next_decode.length   = LEN_THREE;
      next_decode.cycles   = CYC_TWO;
    end else if (match_cmp_ind) begin
      next_decode.valid    = 1'b1;
      next_decode.op_class = BMD_CMP_IND;
      next_decode.reg_num  = {2'h0, opcode[0]};
      next_decode.length   = LEN_THREE;
      next_decode.cycles   = CYC_TWO;
    end else if (match_dec_reg) begin
      next_decode.valid    = 1'b1;
      next_decode.op_class = BMD_DEC_REG;
      next_decode.length   = LEN_THREE;
      next_decode.cycles   = CYC_TWO;
    end else if (match_dec_dir) begin
      next_decode.valid    = 1'b1;
      next_decode.op_class = BMD_DEC_DIR;
      next_decode.length   = LEN_THREE;
      next_decode.cycles   = CYC_TWO;
    end else if (match_extended) begin
      next_decode.length = LEN_ONE;
      // Select codes other than trap and store leave the opcode unknown.
      case (extended_op_select[7:4])
        EXT_SEL_TRAP: begin
          next_decode.valid    = 1'b1;
          next_decode.op_class = BMD_TRAP;
          next_decode.cycles   = CYC_ONE;
        end
        EXT_SEL_STORE: begin
          next_decode.valid    = 1'b1;
          next_decode.op_class = BMD_STORE;
          next_decode.cycles   = CYC_TWO;
        end
        default: begin
          next_decode.valid    = 1'b0;
          next_decode.op_class = BMD_NONE;
        end
      endcase
    end
    // Direct operands that are input pins may be sampled at a bad moment.
    next_decode.port_hazard = operand_is_input_port
                              && match_hazard_op;
  end

  // Relative target: signed displacement plus the following instruction.
  always_comb begin
    branch_in.next_pc      = opcode_pc + {14'h0000, next_decode.length};
    branch_in.displacement = displacement;
    next_target            = branch_in.next_pc
                             + {{8{branch_in.displacement[7]}},
                                branch_in.displacement};
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // A one-cycle strobe for each accepted opcode with a decode class; absolute jumps and calls alone do not raise it.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      decode_valid <= 1'b0;
    end else begin
      decode_valid <= opcode_valid && next_decode.valid;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      decode        <= '{op_class: BMD_NONE, default: '0};
      branch_target <= 16'h0000;
    end else if (opcode_valid) begin
      decode <= next_decode;
      // Absolute forms keep bits 15:11 of the following instruction's address.
      if (next_decode.abs_jump || next_decode.abs_call) begin
        branch_target <= {branch_in.next_pc[15:11], opcode[7:5],
                          displacement};
      end else begin
        branch_target <= next_target;
      end
    end
  end

  // The store writes at the current pointer and hands back the increment.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      store_address     <= 16'h0000;
      data_pointer_next <= 16'h0000;
    end else if (opcode_valid) begin
      store_address     <= data_pointer;
      if (next_decode.op_class == BMD_STORE) begin
        data_pointer_next <= data_pointer + 16'h0001;
      end else begin
        data_pointer_next <= data_pointer;
      end
    end
  end

endmodule // bmd_decoder

//--- design/bmd_pkg.sv
// Package of constants and types for the branch and misc opcode decoder.
package bmd_pkg;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_JUMP_ACC_NZ   = 8'h70;
  localparam logic [7:0] OP_CMP_A_DIR     = 8'hB5;
  localparam logic [7:0] OP_CMP_A_IMM     = 8'hB4;
  localparam logic [4:0] OP_CMP_REG_BASE  = 5'h17;  // B8-BF, bits 7:3.
  localparam logic [6:0] OP_CMP_IND_BASE  = 7'h5B;  // B6-B7, bits 7:1.
  localparam logic [4:0] OP_DEC_REG_BASE  = 5'h1B;  // D8-DF, bits 7:3.
  localparam logic [7:0] OP_DEC_DIR       = 8'hD5;
  localparam logic [7:0] OP_EXTENDED      = 8'hA5;
  localparam logic [4:0] OP_ABS_JUMP_LOW  = 5'h01;  // bits 4:0 of 01..E1.
  localparam logic [4:0] OP_ABS_CALL_LOW  = 5'h11;  // bits 4:0 of 11..F1.

  // ****************************************************************
  // Extended operation select values
  // ****************************************************************
  localparam logic [3:0] EXT_SEL_TRAP     = 4'h0;
  localparam logic [3:0] EXT_SEL_STORE    = 4'h1;

  // ****************************************************************
  // Lengths and cycle counts
  // ****************************************************************
  localparam logic [1:0] LEN_ONE          = 2'h1;
  localparam logic [1:0] LEN_TWO          = 2'h2;
  localparam logic [1:0] LEN_THREE        = 2'h3;
  localparam logic [1:0] CYC_ONE          = 2'h1;
  localparam logic [1:0] CYC_TWO          = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [9:0] {
    BMD_NONE     = 10'h001,
    BMD_JNZ_ACC  = 10'h002,
    BMD_CMP_DIR  = 10'h004,
    BMD_CMP_IMM  = 10'h008,
    BMD_CMP_REG  = 10'h010,
    BMD_CMP_IND  = 10'h020,
    BMD_DEC_REG  = 10'h040,
    BMD_DEC_DIR  = 10'h080,
    BMD_TRAP     = 10'h100,
    BMD_STORE    = 10'h200
  } bmd_class_type;

  typedef struct packed {
    logic          valid;
    bmd_class_type op_class;
    logic [1:0]    length;
    logic [1:0]    cycles;
    logic [2:0]    reg_num;
    logic          abs_jump;
    logic          abs_call;
    logic [2:0]    abs_page;
    logic          port_hazard;
  } bmd_decode_type;

  typedef struct packed {
    logic [15:0] next_pc;
    logic [7:0]  displacement;
  } bmd_branch_type;

endpackage

//--- testbench/bmd_decoder_sva.sv
// Checker tying decoder outputs to the opcode taken one edge earlier.
`timescale 1ns/1ps
module bmd_decoder_sva
  import bmd_pkg::*;
(
  input wire logic           clock,
  input wire logic           arst_n,
  input wire logic           opcode_valid,
  input wire logic [7:0]     opcode,
  input wire logic [15:0]    opcode_pc,
  input wire logic [7:0]     displacement,
  input wire logic [7:0]     extended_op_select,
  input wire logic           operand_is_input_port,
  input wire logic [15:0]    data_pointer,
  input wire logic           decode_valid,
  input wire bmd_decode_type decode,
  input wire logic [15:0]    branch_target,
  input wire logic [15:0]    store_address,
  input wire logic [15:0]    data_pointer_next
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire logic        go  = opcode_valid;
  wire logic [13:0] shp = {decode.op_class, decode.length, decode.cycles};
  wire logic [15:0] rel = opcode_pc + {{8{displacement[7]}}, displacement};
  property p_jnz; go && opcode == 8'h70 |=> decode_valid && shp ==
    {BMD_JNZ_ACC, LEN_TWO, CYC_TWO} && branch_target == $past(rel) + 16'h2;
  endproperty
  a_jnz: assert property (p_jnz) else $error("jump on nonzero bad");
  property p_cmp_a; go && opcode[7:1] == 7'h5A |=> decode_valid && shp ==
    {($past(opcode[0]) ? BMD_CMP_DIR : BMD_CMP_IMM), LEN_THREE, CYC_TWO};
  endproperty
  a_cmp_a: assert property (p_cmp_a) else $error("compare A bad");
  property p_cmp_reg; go && opcode[7:3] == 5'h17 |=> shp == {BMD_CMP_REG,
    LEN_THREE, CYC_TWO} && decode.reg_num == $past(opcode[2:0]); endproperty
  a_cmp_reg: assert property (p_cmp_reg) else $error("compare reg bad");
  property p_cmp_ind; go && opcode[7:1] == 7'h5B |=> shp == {BMD_CMP_IND,
    LEN_THREE, CYC_TWO} && decode.reg_num[0] == $past(opcode[0]); endproperty
  a_cmp_ind: assert property (p_cmp_ind) else $error("compare ind bad");
  property p_dec_reg; go && opcode[7:3] == 5'h1B |=> shp == {BMD_DEC_REG,
    LEN_THREE, CYC_TWO} && branch_target == $past(rel) + 16'h3; endproperty
  a_dec_reg: assert property (p_dec_reg) else $error("dec reg bad");
  property p_dec_dir; go && opcode == 8'hD5 |=> decode_valid && shp ==
    {BMD_DEC_DIR, LEN_THREE, CYC_TWO}; endproperty
  a_dec_dir: assert property (p_dec_dir) else $error("dec direct bad");
  property p_store; go && opcode == 8'hA5 && extended_op_select[7:4] == 4'h1
    |=> shp == {BMD_STORE, LEN_ONE, CYC_TWO} &&
    data_pointer_next == $past(data_pointer) + 16'h1; endproperty
  a_store: assert property (p_store) else $error("store bad");
  property p_abs; go && opcode[3:0] == 4'h1 |=> decode.abs_page ==
    $past(opcode[7:5]) && decode.abs_call == $past(opcode[4]) &&
    decode.abs_jump == !$past(opcode[4]); endproperty
  a_abs: assert property (p_abs) else $error("absolute page bad");
  property p_haz; go && !operand_is_input_port |=> !decode.port_hazard;
  endproperty
  a_haz: assert property (p_haz) else $error("hazard flag bad");
  property p_haz_set; go && operand_is_input_port &&
    (opcode == 8'hB5 || opcode == 8'hD5) |=> decode.port_hazard; endproperty
  a_haz_set: assert property (p_haz_set)
    else $error("hazard flag missing");
  c_store: cover property (go && opcode == 8'hA5 ##1 decode_valid);
  c_back: cover property (go && opcode == 8'hB8 ##1 go && opcode == 8'hD8);
  c_haz: cover property (go ##1 decode.port_hazard);
endmodule // bmd_decoder_sva
bind bmd_decoder bmd_decoder_sva bmd_decoder_sva_inst (.*);

//--- testbench/tb_top.sv
// Self-checking bench for the branch and misc opcode decoder.
`timescale 1ns/1ps
module tb_top;
  import bmd_pkg::*;
  logic           clock = 1'b0;
  logic           arst_n = 1'b0;
  logic           opcode_valid = 1'b0;
  logic           operand_is_input_port = 1'b0;
  logic [7:0]     opcode = 8'h00;
  logic [7:0]     displacement = 8'h00;
  logic [7:0]     extended_op_select = 8'h00;
  logic [15:0]    opcode_pc = 16'h0000;
  logic [15:0]    data_pointer = 16'h0000;
  logic           decode_valid;
  bmd_decode_type decode;
  logic [15:0]    branch_target, store_address, data_pointer_next;
  int             n_errors = 0, checks = 0, cycles = 0;
  bmd_decoder bmd_decoder_inst (.clock, .arst_n, .opcode_valid, .opcode,
    .opcode_pc, .displacement, .extended_op_select, .operand_is_input_port,
    .data_pointer, .decode_valid, .decode, .branch_target, .store_address,
    .data_pointer_next);
  initial forever #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Presents one opcode; returns once its answer has landed.
  task automatic go(input logic [7:0] op, d, sel, input logic [15:0] pc);
    opcode = op;
    displacement = d;
    extended_op_select = sel;
    opcode_pc = pc;
    opcode_valid = 1'b1;
    @(posedge clock);
    #1;
  endtask
  task automatic look(input logic v, input bmd_class_type c,
                      input logic [1:0] l, y);
    chk(16'(decode_valid), 16'(v));
    chk(16'({decode.op_class, decode.length, decode.cycles}), 16'({c, l, y}));
  endtask
  task automatic s_rel();
    go(8'h70, 8'hFE, 8'h00, 16'h0100);
    look(1'b1, BMD_JNZ_ACC, LEN_TWO, CYC_TWO);
    chk(branch_target, 16'h0100);
    go(8'hB5, 8'h7F, 8'h00, 16'hFFF0);
    look(1'b1, BMD_CMP_DIR, LEN_THREE, CYC_TWO);
    chk(branch_target, 16'h0072);
    chk(16'(decode.port_hazard), 16'h0000);
    go(8'hB4, 8'h80, 8'h00, 16'h0200);
    look(1'b1, BMD_CMP_IMM, LEN_THREE, CYC_TWO);
    chk(branch_target, 16'h0183);
    operand_is_input_port = 1'b1;
    go(8'hD5, 8'h00, 8'h00, 16'h0000);
    look(1'b1, BMD_DEC_DIR, LEN_THREE, CYC_TWO);
    chk(16'(decode.port_hazard), 16'h0001);
    operand_is_input_port = 1'b0;
  endtask
  // Software keeps bit tests off live pins; only byte operands are flagged.
  task automatic s_pin();
    operand_is_input_port = 1'b1;
    go(8'hB5, 8'h00, 8'h00, 16'h0000);
    chk(16'(decode.port_hazard), 16'h0001);
    go(8'h20, 8'h00, 8'h00, 16'h0000);
    chk(16'(decode_valid), 16'h0000);
    chk(16'(decode.port_hazard), 16'h0000);
    operand_is_input_port = 1'b0;
  endtask
  task automatic s_blk();
    for (int i = 0; i < 8; i++) begin
      go(8'hB8 + 8'(i), 8'h00, 8'h00, 16'h0000);
      look(1'b1, BMD_CMP_REG, LEN_THREE, CYC_TWO);
      chk(16'(decode.reg_num), 16'(i));
      go(8'hD8 + 8'(i), 8'h00, 8'h00, 16'h0000);
      look(1'b1, BMD_DEC_REG, LEN_THREE, CYC_TWO);
      chk(16'(decode.reg_num), 16'(i));
    end
    for (int i = 0; i < 2; i++) begin
      go(8'hB6 + 8'(i), 8'h00, 8'h00, 16'h0000);
      look(1'b1, BMD_CMP_IND, LEN_THREE, CYC_TWO);
      chk(16'(decode.reg_num[0]), 16'(i));
    end
  endtask
  task automatic s_ext();
    data_pointer = 16'hFFFF;
    go(8'hA5, 8'h00, 8'h10, 16'h0000);
    look(1'b1, BMD_STORE, LEN_ONE, CYC_TWO);
    chk(store_address, 16'hFFFF);
    chk(data_pointer_next, 16'h0000);
    go(8'hA5, 8'h00, 8'h0F, 16'h0000);
    look(1'b1, BMD_TRAP, LEN_ONE, CYC_ONE);
    chk(data_pointer_next, 16'hFFFF);
    go(8'hA5, 8'h00, 8'h20, 16'h0000);
    chk(16'(decode_valid), 16'h0000);
  endtask
  task automatic s_abs();
    for (int i = 0; i < 16; i++) begin
      go({3'(i >> 1), i[0], 4'h1}, 8'h5A, 8'h00, 16'h37FE);
      chk(16'({decode.abs_call, decode.abs_page}), 16'({i[0], 3'(i >> 1)}));
      chk(branch_target, {5'h07, 3'(i >> 1), 8'h5A});
      chk(16'(decode.abs_jump), 16'(!i[0]));
    end
  endtask
  initial begin
    repeat (5) @(posedge clock);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    s_rel();
    s_pin();
    s_blk();
    s_ext();
    s_abs();
    stop_test();
  end
endmodule // tb_top
